/* File: cdc_channel.sv */
// One comparator channel: control and reference code registers, output shaping.
// Assumes a synchronised raw comparator level and single-cycle write strobes.
`timescale 1ns/10ps
module cdc_channel
  import cdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_ctrl,
  input wire logic wr_code,
  input wire logic [15:0] wdata,
  input wire logic idle_halt,
  input wire logic raw_out,
  output logic enable,
  output logic idle_stop,
  output logic run,
  output logic [1:0] input_select,
  output logic [3:0] pin_sel,
  output logic ext_ref,
  output logic pol,
  output logic range_hi,
  output logic [9:0] code,
  output logic state
);
  typedef struct packed {
    logic en;
    logic idl;
    logic [1:0] sel;
    logic ext;
    logic pol;
    logic rng;
    logic [9:0] code;
    logic run;
    logic [3:0] pins;
    logic st;
  } cdc_ch_t;
  cdc_ch_t s_q, s_d;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    if (wr_ctrl) begin
      s_d.en = wdata[ENABLE_BIT];
      s_d.idl = wdata[IDLE_STOP_BIT];
      s_d.sel = wdata[INPUT_SELECT_HI:INPUT_SELECT_LO];
      s_d.ext = wdata[EXTERNAL_REFERENCE_SELECT_BIT];
      s_d.pol = wdata[POL_BIT];
      s_d.rng = wdata[RANGE_BIT];
    end
    if (wr_code) begin
      s_d.code = wdata[CODE_W-1:0];
    end
    // Run only when enabled and not halted by idle
    s_d.run = s_d.en && !idle_halt;
    unique case (s_d.sel)
      SEL_PIN_A: s_d.pins = 4'h1;
      SEL_PIN_B: s_d.pins = 4'h2;
      SEL_PIN_C: s_d.pins = 4'h4;
      SEL_PIN_D: s_d.pins = 4'h8;
    endcase
    // Polarity applied; reads zero while not running
    s_d.st = s_q.run ? (raw_out ^ s_q.pol) : 1'b0;
    if (rst) begin
      s_d = '0;
      s_d.pins = 4'h1;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign enable = s_q.en;
  assign idle_stop = s_q.idl;
  assign run = s_q.run;
  assign input_select = s_q.sel;
  assign pin_sel = s_q.pins;
  assign ext_ref = s_q.ext;
  assign pol = s_q.pol;
  assign range_hi = s_q.rng;
  assign code = s_q.code;
  assign state = s_q.st;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_ctrl_write;
    @(posedge clk) disable iff (rst)
      wr_ctrl |=> (s_q.en == $past(wdata[ENABLE_BIT]) && s_q.sel == $past(wdata[INPUT_SELECT_HI:INPUT_SELECT_LO]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored");

  property p_idle;
    @(posedge clk) disable iff (rst)
      (idle_halt && !wr_ctrl) |=> !s_q.run;
  endproperty
  a_idle: assert property (p_idle) else $error("channel runs during idle halt");

  property p_pins;
    @(posedge clk) disable iff (rst)
      wr_ctrl ##1 1'b1 |=> s_q.pins == (4'h1 << $past(s_q.sel));
  endproperty
  a_pins: assert property (p_pins) else $error("pin select mismatch");

  property p_ext;
    @(posedge clk) disable iff (rst)
      wr_ctrl |=> s_q.ext == $past(wdata[EXTERNAL_REFERENCE_SELECT_BIT]) && s_q.rng == $past(wdata[RANGE_BIT]);
  endproperty
  a_ext: assert property (p_ext) else $error("reference or range not stored");

  property p_pol;
    @(posedge clk) disable iff (rst)
      (s_q.run && !wr_ctrl) |=> s_q.st == ($past(raw_out) ^ $past(s_q.pol));
  endproperty
  a_pol: assert property (p_pol) else $error("output state polarity wrong");

  property p_range;
    @(posedge clk) disable iff (rst)
      !wr_ctrl |=> $stable(s_q.rng);
  endproperty
  a_range: assert property (p_range) else $error("range changed without write");

  property p_code;
    @(posedge clk) disable iff (rst)
      wr_code |=> s_q.code == $past(wdata[CODE_W-1:0]) ##1 ($past(wr_code) || $stable(s_q.code));
  endproperty
  a_code: assert property (p_code) else $error("reference code not held");

  property p_reset;
    @(posedge clk) rst |=> (s_q.en == 1'b0 && s_q.code == '0 && s_q.sel == SEL_PIN_A && !s_q.st);
  endproperty
  a_reset: assert property (p_reset) else $error("channel not cleared by reset");
endmodule : cdc_channel

/* File: cdc_pkg.sv */
// Constants for the four-channel comparator reference control block.
// Shared by the register top and the per-channel slice.
package cdc_pkg;
  localparam int NUM_CMP = 4;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int CODE_W = 10;
  // Register byte offsets
  localparam logic [15:0] CTRL1_OFS = 16'h04C0;
  localparam logic [15:0] CODE1_OFS = 16'h04C2;
  localparam logic [15:0] CTRL2_OFS = 16'h04C4;
  localparam logic [15:0] CODE2_OFS = 16'h04C6;
  localparam logic [15:0] CTRL3_OFS = 16'h04C8;
  localparam logic [15:0] CODE3_OFS = 16'h04CA;
  localparam logic [15:0] CTRL4_OFS = 16'h04CC;
  localparam logic [15:0] CODE4_OFS = 16'h04CE;
  localparam logic [15:0] BASE_OFS = 16'h04C0;
  localparam logic [15:0] LAST_OFS = 16'h04CE;
  // Control field positions
  localparam int ENABLE_BIT = 15;
  localparam int IDLE_STOP_BIT = 13;
  localparam int INPUT_SELECT_HI = 7;
  localparam int INPUT_SELECT_LO = 6;
  localparam int EXTERNAL_REFERENCE_SELECT_BIT = 5;
  localparam int STATE_BIT = 3;
  localparam int POL_BIT = 1;
  localparam int RANGE_BIT = 0;
  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CODE_RST = 16'h0000;
  // Input pin codes
  localparam logic [1:0] SEL_PIN_A = 2'h0;
  localparam logic [1:0] SEL_PIN_B = 2'h1;
  localparam logic [1:0] SEL_PIN_C = 2'h2;
  localparam logic [1:0] SEL_PIN_D = 2'h3;
  // DAC step divisor
  localparam int DAC_STEPS = 1024;
endpackage : cdc_pkg

/* File: cdc_top.sv */
// Register set for four comparator channels with 10-bit reference DACs.
// Assumes a single-cycle strobe register port and raw comparator outputs from the analog side.
// Function
// - Enable bit 15 turns comparator on; zero keeps it off in low power.
// - Idle-stop bit 13 set in any channel halts all comparators during idle; zero in all four keeps them running.
// - Bits 7-6 pick input pin A, B, C or D.
// - Bit 5 feeds the DAC from external reference; zero uses internal.
// - Bit 1 inverts output; bit 3 reads output after polarity.
// - Bit 0 selects high DAC range; zero selects low range.
// - Ten-bit code sets DAC output as code times full scale over 1024.
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
module cdc_top
  import cdc_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [cdc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [cdc_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [cdc_pkg::DATA_W-1:0] RDATA,
  input wire logic IDLE_MODE,
  input wire logic [3:0] CMP_RAW,
  output logic [3:0] CMP_ENABLE,
  output logic [3:0] CMP_RUN,
  output logic [7:0] INPUT_SELECT,
  output logic [15:0] INPUT_PIN_SEL,
  output logic [3:0] EXT_REF_SEL,
  output logic [3:0] OUT_POLARITY,
  output logic [3:0] RANGE_HIGH,
  output logic [39:0] REF_CODE,
  output logic [3:0] OUTPUT_STATE
);
  typedef struct packed {
    logic [3:0] raw_m;
    logic [3:0] raw_s;
    logic idle_m;
    logic idle_s;
    logic [15:0] rdata;
  } cdc_top_t;
  cdc_top_t s_q, s_d;

  logic [3:0] wr_ctrl;
  logic [3:0] wr_code;
  logic [3:0] en_w;
  logic [3:0] idl_w;
  logic [3:0] ext_w;
  logic [3:0] pol_w;
  logic [3:0] rng_w;
  logic [3:0] st_w;
  logic [7:0] sel_w;
  logic [39:0] code_w;
  logic idle_halt;
  logic hit;
  logic [2:0] idx;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  assign hit = (ADDR >= BASE_OFS) && (ADDR <= LAST_OFS) && (ADDR[0] == 1'b0);
  assign idx = 3'(ADDR[3:1]);
  // Any channel with idle-stop set halts all of them while idle
  assign idle_halt = s_q.idle_s && (|idl_w);

  // ----------------------------------------
  // Channel slices
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g++) begin : g_ch
      assign wr_ctrl[g] = WR && hit && (idx == 3'(2 * g));
      assign wr_code[g] = WR && hit && (idx == 3'(2 * g + 1));
      cdc_channel u_ch (
        .clk(CORE_CLK),
        .rst(RST),
        .wr_ctrl(wr_ctrl[g]),
        .wr_code(wr_code[g]),
        .wdata(WDATA),
        .idle_halt(idle_halt),
        .raw_out(s_q.raw_s[g]),
        .enable(en_w[g]),
        .idle_stop(idl_w[g]),
        .run(CMP_RUN[g]),
        .input_select(sel_w[2*g+1:2*g]),
        .pin_sel(INPUT_PIN_SEL[4*g+3:4*g]),
        .ext_ref(ext_w[g]),
        .pol(pol_w[g]),
        .range_hi(rng_w[g]),
        .code(code_w[10*g+9:10*g]),
        .state(st_w[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Next state: synchronisers and read data
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.raw_m = CMP_RAW;
    s_d.raw_s = s_q.raw_m;
    s_d.idle_m = IDLE_MODE;
    s_d.idle_s = s_q.idle_m;
    s_d.rdata = '0;
    if (RD && hit) begin
      if (idx[0] == 1'b0) begin
        s_d.rdata[ENABLE_BIT] = en_w[idx[2:1]];
        s_d.rdata[IDLE_STOP_BIT] = idl_w[idx[2:1]];
        s_d.rdata[INPUT_SELECT_HI:INPUT_SELECT_LO] = sel_w[2*idx[2:1] +: 2];
        s_d.rdata[EXTERNAL_REFERENCE_SELECT_BIT] = ext_w[idx[2:1]];
        s_d.rdata[STATE_BIT] = st_w[idx[2:1]];
        s_d.rdata[POL_BIT] = pol_w[idx[2:1]];
        s_d.rdata[RANGE_BIT] = rng_w[idx[2:1]];
      end else begin
        s_d.rdata[CODE_W-1:0] = code_w[10*idx[2:1] +: 10];
      end
    end
    if (RST) begin
      s_d = '0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge CORE_CLK) begin
    s_q <= s_d;
  end

  // Channel outputs come straight from slice flip-flops
  assign RDATA = s_q.rdata;
  assign CMP_ENABLE = en_w;
  assign INPUT_SELECT = sel_w;
  assign EXT_REF_SEL = ext_w;
  assign OUT_POLARITY = pol_w;
  assign RANGE_HIGH = rng_w;
  assign REF_CODE = code_w;
  assign OUTPUT_STATE = st_w;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_write_ctrl0;
    WR && ADDR == CTRL1_OFS;
  endsequence

  property p_top_enable;
    @(posedge CORE_CLK) disable iff (RST)
      s_write_ctrl0 |=> CMP_ENABLE[0] == $past(WDATA[ENABLE_BIT]);
  endproperty
  a_top_enable: assert property (p_top_enable) else $error("enable not reflected");

  property p_idle_all;
    @(posedge CORE_CLK) disable iff (RST)
      (s_q.idle_s && |idl_w && !WR) |=> CMP_RUN == 4'h0;
  endproperty
  a_idle_all: assert property (p_idle_all) else $error("channel runs while idle stop set");

  property p_readback;
    @(posedge CORE_CLK) disable iff (RST)
      (RD && ADDR == CODE1_OFS && !WR) |=> RDATA == {6'h00, code_w[9:0]};
  endproperty
  a_readback: assert property (p_readback) else $error("code read back wrong");

  property p_unmapped;
    @(posedge CORE_CLK) disable iff (RST)
      (RD && !hit) |=> RDATA == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_state_read;
    @(posedge CORE_CLK) disable iff (RST)
      (RD && ADDR == CTRL1_OFS) |=> RDATA[STATE_BIT] == $past(st_w[0]);
  endproperty
  a_state_read: assert property (p_state_read) else $error("output state read wrong");

  property p_rst_all;
    @(posedge CORE_CLK) RST |=> (CMP_ENABLE == 4'h0 && REF_CODE == '0 && RDATA == 16'h0000);
  endproperty
  a_rst_all: assert property (p_rst_all) else $error("reset left state");
endmodule : cdc_top

/* File: test_comparator_dac_control.sv */
// Self-checking testbench for the four-channel comparator reference register block.
// Assumes the cdc_pkg package; the bench drives every input port of cdc_top directly.
`timescale 1ns/10ps
module test_comparator_dac_control;
  import cdc_pkg::*;
  `define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; $display("Error %0t: got %h exp %h", $time, g, e); end end
  // ------------------------------------------------------------
  // Signals and reference model
  // ------------------------------------------------------------
  logic CORE_CLK = 0, RST = 1, WR = 0, RD = 0, IDLE_MODE = 0, samp = 0, rd_p = 0;
  logic [15:0] ADDR = 0, WDATA = 0, RDATA, a;
  logic [3:0] CMP_RAW = 0, CMP_ENABLE, CMP_RUN, EXT_REF_SEL, OUT_POLARITY, RANGE_HIGH, OUTPUT_STATE;
  logic [7:0] INPUT_SELECT;
  logic [15:0] INPUT_PIN_SEL;
  logic [39:0] REF_CODE;
  logic [87:0] obs;
  logic [175:0] q[$];
  logic [175:0] e;
  logic [15:0] ctl_m[4], code_m[4];
  logic [15:0] tbl_c[4] = '{16'h8000, 16'h8061, 16'h80A2, 16'h00E3};
  logic [15:0] tbl_d[4] = '{16'h0000, 16'h03FF, 16'hFD55, 16'h02AA};
  int mismatches = 0, compares = 0;
  integer seed = 98503;
  // Clock of 25 ns period
  always #12.5 CORE_CLK = ~CORE_CLK;
  cdc_top uut (.CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .IDLE_MODE(IDLE_MODE), .CMP_RAW(CMP_RAW), .CMP_ENABLE(CMP_ENABLE), .CMP_RUN(CMP_RUN),
    .INPUT_SELECT(INPUT_SELECT), .INPUT_PIN_SEL(INPUT_PIN_SEL), .EXT_REF_SEL(EXT_REF_SEL),
    .OUT_POLARITY(OUT_POLARITY), .RANGE_HIGH(RANGE_HIGH), .REF_CODE(REF_CODE), .OUTPUT_STATE(OUTPUT_STATE));
  assign obs = {CMP_RUN, OUTPUT_STATE, CMP_ENABLE, INPUT_SELECT, INPUT_PIN_SEL, EXT_REF_SEL, OUT_POLARITY,
    RANGE_HIGH, REF_CODE};
  // Expected settled outputs from the shadow registers
  function automatic logic [87:0] exp_obs();
    logic [3:0] run, st, en, ext, pol, rng;
    logic [7:0] sel;
    logic [15:0] pin;
    logic [39:0] cd;
    logic halt;
    halt = IDLE_MODE && (ctl_m[0][13] | ctl_m[1][13] | ctl_m[2][13] | ctl_m[3][13]);
    for (int i = 0; i < 4; i++) begin
      en[i] = ctl_m[i][15];
      run[i] = en[i] & !halt;
      pol[i] = ctl_m[i][1];
      st[i] = run[i] & (CMP_RAW[i] ^ pol[i]);
      ext[i] = ctl_m[i][5];
      rng[i] = ctl_m[i][0];
      sel[2*i+:2] = ctl_m[i][7:6];
      pin[4*i+:4] = 4'h1 << ctl_m[i][7:6];
      cd[10*i+:10] = code_m[i][9:0];
    end
    return {run, st, en, sel, pin, ext, pol, rng, cd};
  endfunction : exp_obs
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task automatic op(input logic w, r, s, input logic [15:0] ad, d);
    @(posedge CORE_CLK);
    WR <= w;
    RD <= r;
    samp <= s;
    ADDR <= ad;
    WDATA <= d;
  endtask : op
  task automatic wr(input logic [15:0] ad, d);
    op(1, 0, 0, ad, d);
    if (ad >= BASE_OFS && ad <= LAST_OFS && !ad[0]) begin
      if (ad[1]) code_m[(ad - BASE_OFS) >> 2] = d & 16'h03FF;
      else ctl_m[(ad - BASE_OFS) >> 2] = d & 16'hA0E3;
    end
  endtask : wr
  task automatic rd(input logic [15:0] ad, m);
    logic [87:0] x;
    logic [15:0] v;
    int n;
    x = exp_obs();
    v = 16'h0000;
    n = int'((ad - BASE_OFS) >> 2);
    if (ad >= BASE_OFS && ad <= LAST_OFS && !ad[0])
      v = ad[1] ? code_m[n] : ctl_m[n] | (16'(x[80+n]) << 3);
    q.push_back({72'h0, m, 72'h0, v});
    op(0, 1, 0, ad, 16'h0000);
  endtask : rd
  task automatic chk();
    q.push_back({{88{1'b1}}, exp_obs()});
    op(0, 0, 1, 16'h0000, 16'h0000);
  endtask : chk
  task automatic idle(input int n);
    repeat (n) op(0, 0, 0, 16'h0000, 16'h0000);
  endtask : idle
  task automatic setin(input logic [3:0] r, input logic i);
    @(posedge CORE_CLK);
    CMP_RAW <= r;
    IDLE_MODE <= i;
    WR <= 0;
    RD <= 0;
    samp <= 0;
    idle(6);
  endtask : setin
  task automatic end_of_test();
    $display("TB: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  // ------------------------------------------------------------
  // Monitor: compares each result with the oldest note
  // ------------------------------------------------------------
  always @(posedge CORE_CLK) begin
    // A read result and a settled-output sample can fall on one edge
    if (rd_p) begin
      e = q.pop_front();
      `CHK({72'h0, RDATA} & e[175:88], e[87:0] & e[175:88])
    end
    if (samp) begin
      e = q.pop_front();
      `CHK(obs, e[87:0])
    end
    rd_p = RD;
  end
  // Watchdog against a hang
  initial begin
    #75000;
    mismatches++;
    $display("Error %0t: watchdog expired", $time);
    end_of_test();
  end
  // Main sequence
  initial begin
    for (int i = 0; i < 4; i++) begin
      ctl_m[i] = 0;
      code_m[i] = 0;
    end
    repeat (20) @(posedge CORE_CLK);
    RST <= 0;
    for (int i = 0; i < 8; i++) rd(BASE_OFS + 16'(2 * i), 16'hFFFF);
    chk();
    $display("TB: reset values done");
    repeat (24) begin
      a = BASE_OFS + 16'(2 * ({$random(seed)} % 8));
      wr(a, 16'($random(seed)));
      rd(a, 16'hFFF7);
    end
    setin(4'($random(seed)), 0);
    chk();
    $display("TB: random access done");
    wr(16'h04C1, 16'hFFFF);
    wr(16'h04D0, 16'hFFFF);
    wr(16'h04BE, 16'hFFFF);
    rd(16'h04C1, 16'hFFFF);
    rd(16'h04D0, 16'hFFFF);
    rd(CTRL1_OFS, 16'hFFFF);
    rd(CODE4_OFS, 16'hFFFF);
    $display("TB: unmapped access done");
    for (int i = 0; i < 4; i++) begin
      wr(CTRL1_OFS + 16'(4 * i), tbl_c[i]);
      wr(CODE1_OFS + 16'(4 * i), tbl_d[i]);
    end
    setin(4'h5, 0);
    chk();
    for (int i = 0; i < 4; i++) rd(CTRL1_OFS + 16'(4 * i), 16'hFFFF);
    setin(4'hA, 0);
    chk();
    $display("TB: field table done");
    setin(4'hA, 1);
    chk();
    wr(CTRL2_OFS, 16'hA061);
    setin(4'hA, 1);
    chk();
    rd(CTRL2_OFS, 16'hFFFF);
    setin(4'h5, 0);
    chk();
    $display("TB: idle halt done");
    @(posedge CORE_CLK);
    RST <= 1;
    WR <= 0;
    RD <= 0;
    samp <= 0;
    repeat (2) @(posedge CORE_CLK);
    RST <= 0;
    for (int i = 0; i < 4; i++) begin
      ctl_m[i] = 0;
      code_m[i] = 0;
    end
    for (int i = 0; i < 8; i++) rd(BASE_OFS + 16'(2 * i), 16'hFFFF);
    chk();
    idle(2);
    $display("TB: second reset done");
    end_of_test();
  end
endmodule : test_comparator_dac_control
